// [include/efn_pkg.sv]
// Purpose: shared constants for the error filter and notification stage
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   field positions are bit indices inside each register word
package efn_pkg;

  localparam int unsigned EFN_ENTRIES     = 8;
  localparam int unsigned EFN_AW          = 8;

  // register byte offsets
  localparam logic [7:0]  EFN_FILT_BASE   = 8'h00;  // eight entries, 0x00..0x1c
  localparam logic [7:0]  EFN_FLAG_OFS    = 8'h20;
  localparam logic [7:0]  EFN_COUNT_OFS   = 8'h24;
  localparam logic [7:0]  EFN_CTRL_OFS    = 8'h28;
  localparam logic [7:0]  EFN_CAP_OFS     = 8'h2C;
  localparam logic [7:0]  EFN_TARGET_OFS  = 8'h30;
  localparam logic [7:0]  EFN_ORIGIN_OFS  = 8'h34;

  // filter entry fields
  localparam int unsigned FLT_SRC_LSB     = 0;   // 6 bits
  localparam int unsigned FLT_NUM_LSB     = 8;   // 4 bits, low nibble of code
  localparam int unsigned FLT_GRP_LSB     = 12;  // 4 bits, high nibble of code
  localparam int unsigned FLT_SRC_MASK    = 16;
  localparam int unsigned FLT_GRP_MASK    = 17;
  localparam int unsigned FLT_NUM_MASK    = 18;
  localparam int unsigned FLT_COUNT_EN    = 24;
  localparam int unsigned FLT_FLAG_EN     = 25;
  localparam int unsigned FLT_NOTIFY_EN   = 26;
  localparam int unsigned FLT_HALT_EN     = 27;
  localparam logic [31:0] FLT_RW_MASK     = 32'h0F07_FF3F;

  // error reset register fields
  localparam int unsigned CTRL_FLAG_CLR   = 0;
  localparam int unsigned CTRL_COUNT_CLR  = 1;
  localparam int unsigned CTRL_LOG_CLR    = 2;
  localparam int unsigned CTRL_NOTIFY_EN  = 3;
  localparam int unsigned CTRL_HALT       = 4;

  // capability register fields
  localparam int unsigned CAP_ALL_FLAGS   = 0;
  localparam int unsigned CAP_THRESHOLD   = 1;

  // notify target config fields
  localparam int unsigned TGT_DEST_LSB    = 0;   // 16 bits
  localparam int unsigned TGT_PRIO_LSB    = 16;  // 2 bits
  localparam int unsigned TGT_WIDE        = 20;

  // counter limits
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] CNT_THRESHOLD   = 16'h00FF;

  // port-write header constants
  localparam logic [3:0]  PW_FTYPE        = 4'h8;
  localparam logic [3:0]  PW_TTYPE        = 4'h4;
  localparam logic [3:0]  PW_WRSIZE       = 4'hB;
  localparam logic [7:0]  PW_HOP          = 8'hFF;
  localparam logic [1:0]  PW_TT_SMALL     = 2'h0;
  localparam logic [1:0]  PW_TT_WIDE      = 2'h1;

endpackage : efn_pkg

// [logic/efn_top.sv]
// Purpose: special error filter, flag, counter, halt and port-write notify
// Assumes: errors arrive as one-cycle pulses from logic on clk
// Notes:   apb slave answers with no wait states; prdata is loaded in setup
//
// Behaviour
// RULE1 - eight filter entries each enable count, flag, notify or halt on a match
// RULE2 - source, group and number fields can each be masked out of the compare
// RULE3 - a match with flag enable sets that entry's own flag bit
// RULE4 - flag bits accumulate; new matches never clear older bits
// RULE5 - reading the flag register returns the bits and then clears them all
// RULE6 - flags clear on manager reset or on the flag-clear control bit
// RULE7 - open-drain interrupt pulled low while any flag bit is set
// RULE8 - 16-bit counter adds one per error matching a count-enabled entry
// RULE9 - counter saturates at all ones until cleared
// RULE10 - counter clears on manager reset or on the counter-clear control bit
// RULE11 - a match on a halt-enabled entry halts the manager
// RULE12 - writing one to the halt bit halts; writing zero resumes
// RULE13 - while halted every new error is dropped with no effect at all
// RULE14 - option on and all flags set: set halt bit and send notification
// RULE15 - option on and counter reaches threshold: set halt bit and notify
// RULE16 - reset register clears flags, counter, log; holds notify enable and halt
// RULE17 - a notification only follows a triggered action and only when enabled
// RULE18 - destination id and priority come from the target config register
// RULE19 - transport type and id width follow the wide id select field
// RULE20 - source id comes from the origin id register
// RULE21 - port-write: ttype 0100, wrsize 1011, ftype 1000, crf 0, hop ff, wptr 0
// RULE22 - payload: two zeros, source, code, flags, counter, 24 zero bits
// RULE23 - error code holds group in the upper nibble, number in the lower
// RULE24 - several matching entries act together; counter adds at most one
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module efn_top
  import efn_pkg::*;
(
  input  wire logic              clk,            // core clock, 125 MHz
  input  wire logic              rstn,           // error manager reset, async low
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb write
  input  wire logic [EFN_AW-1:0] paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  output logic      [31:0]       prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error, unmapped address
  input  wire logic              err_valid,      // detected error pulse
  input  wire logic [5:0]        err_source,     // error source
  input  wire logic [7:0]        err_code,       // group in [7:4], number in [3:0]
  output logic                   err_pass,       // error accepted, forward to log
  output logic                   log_clear,      // pulse, clear the error log
  output logic                   manager_halted, // error manager frozen
  output logic                   irq_n_o,        // interrupt pin output level
  output logic                   irq_n_oe,       // interrupt pin drive enable
  output logic                   pw_valid,       // port-write packet ready
  input  wire logic              pw_ready,       // transmitter takes packet
  output logic                   pw_crf,         // critical request flow
  output logic      [1:0]        pw_prio,        // packet priority
  output logic      [1:0]        pw_tt,          // transport type
  output logic      [3:0]        pw_ftype,       // format type
  output logic      [15:0]       pw_dest_id,     // destination id
  output logic      [15:0]       pw_src_id,      // source id
  output logic      [3:0]        pw_ttype,       // transaction type
  output logic      [3:0]        pw_wrsize,      // write size
  output logic      [7:0]        pw_hop,         // hop count
  output logic                   pw_wptr,        // word pointer
  output logic      [63:0]       pw_payload      // the single data word
);

  typedef struct packed {
    logic [EFN_ENTRIES-1:0][31:0] filt;
    logic [EFN_ENTRIES-1:0]       flags;
    logic [15:0]                  count;
    logic                         notify_en;
    logic                         halt;
    logic [1:0]                   cap;
    logic [15:0]                  tgt_dest;
    logic [1:0]                   tgt_prio;
    logic                         tgt_wide;
    logic [15:0]                  origin;
    logic [31:0]                  rdata;
    logic                         slverr;
    logic                         log_clr;
    logic                         pass;
    logic                         pw_vld;
    logic [1:0]                   pw_pri;
    logic                         pw_wide;
    logic [15:0]                  pw_dst;
    logic [15:0]                  pw_src;
    logic [5:0]                   pw_esrc;
    logic [7:0]                   pw_code;
    logic [7:0]                   pw_flags;
    logic [15:0]                  pw_cnt;
  } efn_state_t;

  efn_state_t r;
  efn_state_t next_r;

  logic [EFN_ENTRIES-1:0] match;

  // per-entry compare; a masked field always agrees
  for (genvar i = 0; i < EFN_ENTRIES; i++) begin : g_match
    logic src_ok;
    logic grp_ok;
    logic num_ok;
    assign src_ok = r.filt[i][FLT_SRC_MASK] ||
                    (r.filt[i][FLT_SRC_LSB +: 6] == err_source);  // [RULE2]
    assign grp_ok = r.filt[i][FLT_GRP_MASK] ||
                    (r.filt[i][FLT_GRP_LSB +: 4] == err_code[7:4]); // [RULE2] [RULE23]
    assign num_ok = r.filt[i][FLT_NUM_MASK] ||
                    (r.filt[i][FLT_NUM_LSB +: 4] == err_code[3:0]); // [RULE2] [RULE23]
    assign match[i] = src_ok && grp_ok && num_ok;                   // [RULE1]
  end

  always_comb begin
    logic                   setup;
    logic                   wr;
    logic                   rd;
    logic                   hit;
    logic [31:0]            rmux;
    logic                   ev;
    logic [EFN_ENTRIES-1:0] hits;
    logic [EFN_ENTRIES-1:0] en_cnt;
    logic [EFN_ENTRIES-1:0] en_flag;
    logic [EFN_ENTRIES-1:0] en_ntf;
    logic [EFN_ENTRIES-1:0] en_halt;
    logic                   flag_clr;
    logic                   cnt_clr;
    logic [EFN_ENTRIES-1:0] flags_new;
    logic [15:0]            cnt_base;
    logic [15:0]            cnt_new;
    logic                   cnt_inc;
    logic                   all_trig;
    logic                   thr_trig;
    logic                   halt_hit;
    logic                   send;

    next_r   = r;
    setup    = psel && !penable;
    wr       = psel && penable && pwrite;
    rd       = psel && penable && !pwrite;
    hit      = 1'b1;
    rmux     = 32'h0000_0000;
    en_cnt   = '0;
    en_flag  = '0;
    en_ntf   = '0;
    en_halt  = '0;
    // every local gets a value up front so no path can infer a latch
    ev        = 1'b0;
    hits      = '0;
    flag_clr  = 1'b0;
    cnt_clr   = 1'b0;
    flags_new = '0;
    cnt_base  = 16'h0000;
    cnt_new   = 16'h0000;
    cnt_inc   = 1'b0;
    all_trig  = 1'b0;
    thr_trig  = 1'b0;
    halt_hit  = 1'b0;
    send      = 1'b0;

    for (int i = 0; i < EFN_ENTRIES; i++) begin
      en_cnt[i]  = r.filt[i][FLT_COUNT_EN];
      en_flag[i] = r.filt[i][FLT_FLAG_EN];
      en_ntf[i]  = r.filt[i][FLT_NOTIFY_EN];
      en_halt[i] = r.filt[i][FLT_HALT_EN];
    end

    // read mux, sampled in the setup cycle so prdata is a flop in access
    if (paddr < EFN_FLAG_OFS) begin
      rmux = r.filt[paddr[4:2]];
    end else begin
      unique case (paddr)
        EFN_FLAG_OFS:   rmux = {24'h00_0000, r.flags};
        EFN_COUNT_OFS:  rmux = {16'h0000, r.count};
        EFN_CTRL_OFS: begin
          rmux[CTRL_NOTIFY_EN] = r.notify_en;
          rmux[CTRL_HALT]      = r.halt;
        end
        EFN_CAP_OFS:    rmux = {30'h0000_0000, r.cap};
        EFN_TARGET_OFS: begin
          rmux[TGT_DEST_LSB +: 16] = r.tgt_dest;
          rmux[TGT_PRIO_LSB +: 2]  = r.tgt_prio;
          rmux[TGT_WIDE]           = r.tgt_wide;
        end
        EFN_ORIGIN_OFS: rmux = {16'h0000, r.origin};
        default:        hit  = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
    if (setup) begin
      next_r.rdata  = hit ? rmux : 32'h0000_0000;
      next_r.slverr = !hit;
    end

    // register writes; a refused access changes nothing
    flag_clr = rd && !r.slverr && (paddr == EFN_FLAG_OFS);            // [RULE5]
    cnt_clr  = 1'b0;
    next_r.log_clr = 1'b0;
    if (wr && !r.slverr) begin
      if (paddr < EFN_FLAG_OFS) begin
        next_r.filt[paddr[4:2]] = pwdata & FLT_RW_MASK;               // [RULE1]
      end else begin
        unique case (paddr)
          EFN_CTRL_OFS: begin
            flag_clr         = flag_clr || pwdata[CTRL_FLAG_CLR];     // [RULE6] [RULE16]
            cnt_clr          = pwdata[CTRL_COUNT_CLR];                // [RULE10] [RULE16]
            next_r.log_clr   = pwdata[CTRL_LOG_CLR];                  // [RULE16]
            next_r.notify_en = pwdata[CTRL_NOTIFY_EN];                // [RULE16]
            next_r.halt      = pwdata[CTRL_HALT];                     // [RULE12]
          end
          EFN_CAP_OFS:    next_r.cap = pwdata[1:0];
          EFN_TARGET_OFS: begin
            next_r.tgt_dest = pwdata[TGT_DEST_LSB +: 16];             // [RULE18]
            next_r.tgt_prio = pwdata[TGT_PRIO_LSB +: 2];              // [RULE18]
            next_r.tgt_wide = pwdata[TGT_WIDE];                       // [RULE19]
          end
          EFN_ORIGIN_OFS: next_r.origin = pwdata[15:0];               // [RULE20]
          default: ;
        endcase
      end
    end

    // error path: a frozen manager sees nothing
    ev       = err_valid && !r.halt;                                  // [RULE13]
    hits     = ev ? match : '0;                                       // [RULE24]
    next_r.pass = ev;                                                 // [RULE13]
    halt_hit = |(hits & en_halt);                                     // [RULE11]
    cnt_inc  = |(hits & en_cnt);                                      // [RULE8] [RULE24]

    // set wins over any clear landing in the same cycle
    flags_new = (flag_clr ? '0 : r.flags) | (hits & en_flag);         // [RULE3] [RULE4]
    next_r.flags = flags_new;

    cnt_base = cnt_clr ? 16'h0000 : r.count;                          // [RULE10]
    cnt_new  = cnt_base;
    if (cnt_inc && (cnt_base != CNT_MAX)) begin                       // [RULE9]
      cnt_new = cnt_base + 16'h0001;                                  // [RULE8]
    end
    next_r.count = cnt_new;

    all_trig = r.cap[CAP_ALL_FLAGS] && (&flags_new) && !(&r.flags);   // [RULE14]
    thr_trig = r.cap[CAP_THRESHOLD] && (cnt_new == CNT_THRESHOLD) &&
               (r.count != CNT_THRESHOLD);                            // [RULE15]

    // hardware halt wins over a software resume in the same cycle
    if (halt_hit || all_trig || thr_trig) begin
      next_r.halt = 1'b1;                                             // [RULE11] [RULE14] [RULE15]
    end

    // packet slot drains on handshake; a trigger while still full is dropped
    if (r.pw_vld && pw_ready) begin
      next_r.pw_vld = 1'b0;
    end
    send = r.notify_en && ((|(hits & en_ntf)) || all_trig || thr_trig); // [RULE17]
    if (send && (!r.pw_vld || pw_ready)) begin
      next_r.pw_vld   = 1'b1;
      next_r.pw_pri   = r.tgt_prio;                                   // [RULE18]
      next_r.pw_wide  = r.tgt_wide;                                   // [RULE19]
      next_r.pw_dst   = r.tgt_wide ? r.tgt_dest : {8'h00, r.tgt_dest[7:0]}; // [RULE19]
      next_r.pw_src   = r.tgt_wide ? r.origin : {8'h00, r.origin[7:0]};     // [RULE20]
      next_r.pw_esrc  = err_source;
      next_r.pw_code  = err_code;
      next_r.pw_flags = flags_new;
      next_r.pw_cnt   = cnt_new;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;                                                        // [RULE6] [RULE10]
    end else begin
      r <= next_r;
    end
  end

  assign prdata         = r.rdata;
  assign pready         = psel && penable;
  assign pslverr        = psel && penable && r.slverr;
  assign err_pass       = r.pass;
  assign log_clear      = r.log_clr;
  assign manager_halted = r.halt;
  // open drain: only ever pulls low; wired-or with other devices on the board
  assign irq_n_o        = 1'b0;
  assign irq_n_oe       = |r.flags;                                   // [RULE7]

  assign pw_valid   = r.pw_vld;
  assign pw_crf     = 1'b0;                                           // [RULE21]
  assign pw_prio    = r.pw_pri;
  assign pw_tt      = r.pw_wide ? PW_TT_WIDE : PW_TT_SMALL;           // [RULE19]
  assign pw_ftype   = PW_FTYPE;                                       // [RULE21]
  assign pw_dest_id = r.pw_dst;
  assign pw_src_id  = r.pw_src;
  assign pw_ttype   = PW_TTYPE;                                       // [RULE21]
  assign pw_wrsize  = PW_WRSIZE;                                      // [RULE21]
  assign pw_hop     = PW_HOP;                                         // [RULE21]
  assign pw_wptr    = 1'b0;                                           // [RULE21]
  assign pw_payload = {2'b00, r.pw_esrc, r.pw_code, r.pw_flags,
                       r.pw_cnt, 24'h00_0000};                        // [RULE22]

endmodule : efn_top

// [tb/efn_sva.sv]
// Purpose: port assertions for the error filter and notify stage
// Assumes: zero-wait apb, one clock domain
// Notes:   flag contents are seen only via reads and the interrupt pin
`timescale 1ns/1ps
module efn_sva
  import efn_pkg::*;
(
  input logic        clk,            // clock
  input logic        rstn,           // reset
  input logic        psel,           // apb
  input logic        penable,        // apb
  input logic        pwrite,         // apb
  input logic [7:0]  paddr,          // apb
  input logic [31:0] pwdata,         // apb
  input logic [31:0] prdata,         // apb
  input logic        err_valid,      // error pulse
  input logic        err_pass,       // accepted
  input logic        log_clear,      // log clear
  input logic        manager_halted, // halt
  input logic        irq_n_o,        // pin level
  input logic        irq_n_oe,       // pin enable
  input logic        pw_valid,       // packet
  input logic        pw_ready,       // taken
  input logic        pw_crf,         // header
  input logic [3:0]  pw_ftype,       // header
  input logic [3:0]  pw_ttype,       // header
  input logic [3:0]  pw_wrsize,      // header
  input logic [7:0]  pw_hop,         // header
  input logic        pw_wptr,        // header
  input logic [63:0] pw_payload      // data word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_flag;
    psel && penable && !pwrite && paddr == EFN_FLAG_OFS;
  endsequence
  sequence s_wr_ctrl;
    psel && penable && pwrite && paddr == EFN_CTRL_OFS;
  endsequence

  AST_IRQ_PIN: assert property (irq_n_oe |-> !irq_n_o)
    else $error("interrupt pin driven high");
  // prdata was loaded one edge earlier, so an error in the setup cycle is excluded
  AST_FLAG_RD: assert property (s_rd_flag ##0 !$past(err_valid)
    |-> (prdata != 32'h0000_0000) == irq_n_oe) else $error("flag read and pin disagree");
  AST_FLAG_CLR: assert property (s_rd_flag ##0 !err_valid |=> !irq_n_oe)
    else $error("flags not cleared by read");
  AST_DROP: assert property (manager_halted && err_valid |=> !err_pass)
    else $error("error passed while halted");
  AST_PASS: assert property (!manager_halted && err_valid |=> err_pass)
    else $error("error not taken");
  AST_HALT_SET: assert property (s_wr_ctrl ##0 pwdata[4] |=> manager_halted)
    else $error("halt write ignored");
  AST_RESUME: assert property (s_wr_ctrl ##0 !pwdata[4] && !err_valid
    |=> !manager_halted) else $error("resume write ignored");
  AST_LOG: assert property (s_wr_ctrl ##0 pwdata[2] |=> log_clear)
    else $error("log clear missing");
  AST_PW_HDR: assert property (pw_valid |-> pw_ftype == 4'h8 && pw_ttype == 4'h4
    && pw_wrsize == 4'hB && pw_hop == 8'hFF && !pw_crf && !pw_wptr)
    else $error("port-write header wrong");
  AST_PW_PAD: assert property (pw_valid |-> pw_payload[63:62] == 2'b00
    && pw_payload[23:0] == 24'h00_0000) else $error("payload padding wrong");
  AST_PW_HOLD: assert property (pw_valid && !pw_ready |=> pw_valid
    && $stable(pw_payload)) else $error("packet changed before taken");
  AST_PW_CAUSE: assert property ($rose(pw_valid)
    |-> $past(err_valid) && !$past(manager_halted)) else $error("packet without error");
endmodule : efn_sva

// [tb/efn_pw_sink.sv]
// Purpose: far-side receiver of port-write packets
// Assumes: ready may lag valid by a chosen number of cycles
// Notes:   keeps only the last packet and a running count
`timescale 1ns/1ps
module efn_pw_sink (
  input  logic        clk,        // clock
  input  logic        rstn,       // reset
  input  logic [3:0]  stall,      // ready delay
  input  logic        pw_valid,   // offered
  output logic        pw_ready,   // taken
  input  logic [1:0]  pw_prio,    // priority
  input  logic [1:0]  pw_tt,      // transport
  input  logic [15:0] pw_dest_id, // destination
  input  logic [15:0] pw_src_id,  // source
  input  logic [63:0] pw_payload, // data word
  output logic [35:0] rx_hdr,     // last header
  output logic [63:0] rx_data,    // last data
  output int          rx_count    // packets taken
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pw_ready <= 1'b0;
      wait_cnt <= 4'h0;
      rx_hdr   <= '0;
      rx_data  <= '0;
      rx_count <= 0;
    end else if (pw_valid && pw_ready) begin
      rx_hdr   <= {pw_prio, pw_tt, pw_dest_id, pw_src_id};
      rx_data  <= pw_payload;
      rx_count <= rx_count + 1;
      pw_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (pw_valid && wait_cnt >= stall) begin
      pw_ready <= 1'b1;
    end else if (pw_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : efn_pw_sink

// [tb/error_filter_notify_bench.sv]
// Purpose: self-checking bench for the error filter and notify stage
// Assumes: zero-wait apb slave; at most one error per cycle
// Notes:   the saturation run dominates, about 66k cycles
`timescale 1ns/1ps
module error_filter_notify_bench
  import efn_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, err_valid, pready, pslverr, rd_err;
  logic        err_pass, log_clear, manager_halted, irq_n_o, irq_n_oe;
  logic        pw_valid, pw_ready, pw_crf, pw_wptr;
  logic [7:0]  paddr, err_code, pw_hop;
  logic [5:0]  err_source;
  logic [31:0] pwdata, prdata, rd_q;
  logic [1:0]  pw_prio, pw_tt;
  logic [3:0]  pw_ftype, pw_ttype, pw_wrsize, stall;
  logic [15:0] pw_dest_id, pw_src_id;
  logic [63:0] pw_payload, rx_data;
  logic [35:0] rx_hdr;
  int          rx_count, n_mismatch, total_checks;
  int          cycles = 0;
  wire         irq_line = irq_n_oe ? irq_n_o : 1'b1; // shared line has a pull-up

  efn_top     i_dut (.*);
  efn_pw_sink i_sink (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic cmp(input string what, input logic [63:0] want, input logic [63:0] got);
    total_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q    = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    cmp($sformatf("reg %h", a), want, rd_q);
  endtask : rd
  // errors held high for n back-to-back cycles
  task automatic burst(input logic [5:0] s, input logic [7:0] c, input int n);
    err_source <= s;
    err_code   <= c;
    err_valid  <= 1'b1;
    repeat (n) @(posedge clk);
    err_valid  <= 1'b0;
    @(posedge clk);
  endtask : burst
  task automatic wait_rx(input int n);
    for (int k = 0; k < 40 && rx_count != n; k++) @(posedge clk);
    cmp("packets", n, rx_count);
  endtask : wait_rx
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, err_valid, paddr, pwdata, err_source, err_code, stall} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(EFN_FLAG_OFS, 32'h0000_0000);
    rd(EFN_COUNT_OFS, 32'h0000_0000);
    rd(8'h38, 32'h0000_0000);
    cmp("slave error", 1'b1, rd_err);
    // all eight flags with the auto-halt option
    wr(EFN_CAP_OFS, 32'h0000_0001);
    wr(EFN_CTRL_OFS, 32'h0000_0008);
    for (int i = 0; i < 8; i++) wr(8'(4 * i), 32'h0300_8000 | (i << 8) | i);
    for (int i = 0; i < 8; i++) begin
      burst(6'(i), {4'h8, 4'(i)}, 1);
      cmp("irq line", 1'b0, irq_line);
      cmp("halted", (i == 7), manager_halted);
    end
    wait_rx(1);
    cmp("pw data", {2'b00, 6'd7, 8'h87, 8'hFF, 16'h0008, 24'h0}, rx_data);
    cmp("pw header", 36'h0, rx_hdr);
    burst(6'd0, 8'h80, 1);
    rd(EFN_FLAG_OFS, 32'h0000_00FF);
    rd(EFN_FLAG_OFS, 32'h0000_0000);
    cmp("irq line", 1'b1, irq_line);
    rd(EFN_COUNT_OFS, 32'h0000_0008);
    rd(EFN_CTRL_OFS, 32'h0000_0018);
    wr(EFN_CTRL_OFS, 32'h0000_0008);
    cmp("halted", 1'b0, manager_halted);
    // masked fields, group and number mismatches, two entries on one error
    wr(EFN_CAP_OFS, 32'h0000_0000);
    wr(8'h00, 32'h0107_0000);
    wr(8'h04, 32'h0107_0000);
    wr(8'h08, 32'h0301_8202);
    burst(6'h15, 8'h82, 1);
    burst(6'h02, 8'h92, 1);
    burst(6'h03, 8'h38, 1);
    rd(EFN_FLAG_OFS, 32'h0000_0004);
    rd(EFN_COUNT_OFS, 32'h0000_000B);
    burst(6'h15, 8'h82, 1);
    wr(EFN_CTRL_OFS, 32'h0000_0007);
    cmp("irq line", 1'b1, irq_line);
    rd(EFN_COUNT_OFS, 32'h0000_0000);
    burst(6'h00, 8'h00, 65540);
    rd(EFN_COUNT_OFS, 32'h0000_FFFF);
    wr(EFN_CTRL_OFS, 32'h0000_0002);
    // counter threshold, wide ids, slow receiver
    stall <= 4'd5;
    wr(EFN_TARGET_OFS, 32'h0012_A5C3);
    wr(EFN_ORIGIN_OFS, 32'h0000_1234);
    wr(EFN_CAP_OFS, 32'h0000_0002);
    wr(EFN_CTRL_OFS, 32'h0000_0008);
    burst(6'h2A, 8'h9F, 255);
    cmp("halted", 1'b1, manager_halted);
    wait_rx(2);
    cmp("pw header", {2'd2, PW_TT_WIDE, 16'hA5C3, 16'h1234}, rx_hdr);
    cmp("pw data", {2'b00, 6'h2A, 8'h9F, 8'h00, 16'h00FF, 24'h0}, rx_data);
    // filter notify and halt, narrow ids
    stall <= 4'd0;
    wr(EFN_TARGET_OFS, 32'h0001_A5C3);
    wr(8'h0C, 32'h0E00_8303);
    wr(EFN_CTRL_OFS, 32'h0000_000A);
    burst(6'h03, 8'h83, 1);
    cmp("halted", 1'b1, manager_halted);
    wait_rx(3);
    cmp("pw header", {2'd1, PW_TT_SMALL, 16'h00C3, 16'h0034}, rx_hdr);
    cmp("pw data", {2'b00, 6'h03, 8'h83, 8'h08, 16'h0001, 24'h0}, rx_data);
    wr(EFN_CTRL_OFS, 32'h0000_0000);
    burst(6'h03, 8'h83, 1);
    rd(EFN_FLAG_OFS, 32'h0000_0008);
    cmp("packets", 3, rx_count);
    wr(EFN_CTRL_OFS, 32'h0000_0000);
    cmp("halted", 1'b0, manager_halted);
    // manager reset in mid-run with a flag, a count and a halt pending
    burst(6'h03, 8'h83, 1);
    cmp("irq line", 1'b0, irq_line);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("halted", 1'b0, manager_halted);
    cmp("irq line", 1'b1, irq_line);
    rd(EFN_FLAG_OFS, 32'h0000_0000);
    rd(EFN_COUNT_OFS, 32'h0000_0000);
    wr(EFN_CTRL_OFS, 32'h0000_0010);
    cmp("halted", 1'b1, manager_halted);
    final_report();
  end
endmodule : error_filter_notify_bench

bind efn_top efn_sva i_sva (.*);
